// file: include/smcr_pkg.sv
// Package of constants and types for the switch management configuration registers.
`default_nettype none

package smcr_pkg;

    localparam logic [7:0] SMCR_OFS_GLOBAL_CFG = 8'h00;
    localparam logic [7:0] SMCR_OFS_TAG_CTRL = 8'h03;
    localparam logic [7:0] SMCR_OFS_STEER_LO = 8'h04;
    localparam logic [7:0] SMCR_OFS_STEER_HI = 8'h05;

    localparam logic [7:0] SMCR_RST_GLOBAL_CFG = 8'h00;
    localparam logic [7:0] SMCR_RST_TAG_CTRL = 8'h00;
    localparam logic [15:0] SMCR_RST_STEER = 16'h0000;
    localparam logic [7:0] SMCR_RDATA_UNMAPPED = 8'h00;

    localparam int SMCR_SEL_HI = 7;
    localparam int SMCR_SEL_LO = 6;
    localparam int SMCR_BPDU_BIT = 1;
    localparam int SMCR_CLEAR_BIT = 0;
    localparam int SMCR_TAG_PRI_BIT = 0;
    localparam int SMCR_TAG_SEC_BIT = 1;
    localparam int SMCR_STEER_WIDTH = 9;
    localparam logic [8:0] SMCR_STEER_USED_MASK = 9'h13F;

    localparam logic [1:0] SMCR_SEL_NONE = 2'h0;
    localparam logic [1:0] SMCR_SEL_RSVD = 2'h1;
    localparam logic [1:0] SMCR_SEL_PRIMARY = 2'h2;
    localparam logic [1:0] SMCR_SEL_DUAL = 2'h3;

    localparam logic [3:0] SMCR_PORT_PRIMARY = 4'h8;
    localparam logic [3:0] SMCR_PORT_SECONDARY = 4'h5;
    localparam logic [3:0] SMCR_PORT_NONE = 4'h0;

    typedef enum logic [1:0] {
        SMCR_MODE_NONE = 2'b00,
        SMCR_MODE_PRIMARY = 2'b01,
        SMCR_MODE_DUAL = 2'b10
    } smcr_mode_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smcr_reg_req_type;

    typedef struct packed {
        logic valid;
        logic from_wan;
    } smcr_cpu_req_type;

    typedef struct packed {
        logic valid;
        logic forward;
        logic [3:0] port;
    } smcr_dest_type;

endpackage : smcr_pkg

`default_nettype wire

// file: rtl/smcr_cpu_route.sv
// Destination choice for CPU-bound frames from the management mode.
`default_nettype none

module smcr_cpu_route (
    input wire logic clk_sys,
    input wire logic rst,
    input wire smcr_pkg::smcr_mode_type mode,
    input wire smcr_pkg::smcr_cpu_req_type req,
    output smcr_pkg::smcr_dest_type dest
);
    import smcr_pkg::*;

    smcr_dest_type dest_reg;
    smcr_dest_type dest_next;

    always_comb begin
        dest_next = '0;
        dest_next.valid = req.valid;
        dest_next.port = SMCR_PORT_NONE;
        unique case (mode)
            SMCR_MODE_NONE: begin
                dest_next.forward = 1'b0;
            end
            SMCR_MODE_PRIMARY: begin
                dest_next.forward = req.valid;
                dest_next.port = SMCR_PORT_PRIMARY;
            end
            SMCR_MODE_DUAL: begin
                dest_next.forward = req.valid;
                dest_next.port = req.from_wan ? SMCR_PORT_SECONDARY : SMCR_PORT_PRIMARY;
            end
            default: begin
                dest_next.forward = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dest_reg <= '0;
        end else begin
            dest_reg <= dest_next;
        end
    end

    assign dest = dest_reg;

endmodule : smcr_cpu_route

`default_nettype wire

// file: rtl/smcr_tag_filter.sv
// Tag header insert and ingress check for one management port.
`default_nettype none

module smcr_tag_filter (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tag_enable,
    input wire logic rx_valid,
    input wire logic rx_has_tag,
    output logic tx_insert,
    output logic rx_accept,
    output logic rx_discard
);
    logic insert_reg;
    logic insert_next;
    logic accept_reg;
    logic accept_next;
    logic discard_reg;
    logic discard_next;

    always_comb begin
        insert_next = tag_enable;
        accept_next = rx_valid && (!tag_enable || rx_has_tag);
        discard_next = rx_valid && tag_enable && !rx_has_tag;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            insert_reg <= 1'b0;
            accept_reg <= 1'b0;
            discard_reg <= 1'b0;
        end else begin
            insert_reg <= insert_next;
            accept_reg <= accept_next;
            discard_reg <= discard_next;
        end
    end

    assign tx_insert = insert_reg;
    assign rx_accept = accept_reg;
    assign rx_discard = discard_reg;

endmodule : smcr_tag_filter

`default_nettype wire

// file: rtl/smcr_regs.sv
// Management configuration register bank with routing, trap, clear, tag and steering controls.
`default_nettype none

module smcr_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire smcr_pkg::smcr_reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic unmanaged_mode,
    input wire smcr_pkg::smcr_cpu_req_type cpu_req,
    output smcr_pkg::smcr_dest_type cpu_dest,
    input wire logic bpdu_valid,
    output smcr_pkg::smcr_dest_type bpdu_dest,
    output logic counter_clear,
    output logic [1:0] tag_insert,
    input wire logic [1:0] mgmt_rx_valid,
    input wire logic [1:0] mgmt_rx_has_tag,
    output logic [1:0] mgmt_rx_accept,
    output logic [1:0] mgmt_rx_discard,
    output logic [8:0] counter_tx_side,
    output logic [1:0] active_mode
);
    import smcr_pkg::*;

    logic [7:0] global_cfg_reg;
    logic [7:0] global_cfg_next;
    logic [7:0] tag_ctrl_reg;
    logic [7:0] tag_ctrl_next;
    logic [15:0] steer_reg;
    logic [15:0] steer_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic clear_reg;
    logic clear_next;
    logic [8:0] tx_side_reg;
    logic [8:0] tx_side_next;
    smcr_mode_type mode_reg;
    smcr_mode_type mode_next;
    smcr_dest_type bpdu_reg;
    smcr_dest_type bpdu_next;
    logic [1:0] tag_eff;
    logic wr_global;

    // Register writes and reads.
    always_comb begin
        global_cfg_next = global_cfg_reg;
        tag_ctrl_next = tag_ctrl_reg;
        steer_next = steer_reg;
        rdata_next = rdata_reg;
        rvalid_next = reg_req.rd;
        wr_global = reg_req.wr && (reg_req.addr == SMCR_OFS_GLOBAL_CFG);
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                SMCR_OFS_GLOBAL_CFG: begin
                    global_cfg_next = reg_req.wdata;
                end
                SMCR_OFS_TAG_CTRL: begin
                    tag_ctrl_next = reg_req.wdata;
                end
                SMCR_OFS_STEER_LO: begin
                    steer_next[7:0] = reg_req.wdata;
                end
                SMCR_OFS_STEER_HI: begin
                    steer_next[15:8] = reg_req.wdata;
                end
                default: begin
                    global_cfg_next = global_cfg_reg;
                end
            endcase
        end
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                SMCR_OFS_GLOBAL_CFG: begin
                    rdata_next = global_cfg_reg;
                end
                SMCR_OFS_TAG_CTRL: begin
                    rdata_next = tag_ctrl_reg;
                end
                SMCR_OFS_STEER_LO: begin
                    rdata_next = steer_reg[7:0];
                end
                SMCR_OFS_STEER_HI: begin
                    rdata_next = steer_reg[15:8];
                end
                default: begin
                    rdata_next = SMCR_RDATA_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            global_cfg_reg <= SMCR_RST_GLOBAL_CFG;
            tag_ctrl_reg <= SMCR_RST_TAG_CTRL;
            steer_reg <= SMCR_RST_STEER;
            rdata_reg <= SMCR_RDATA_UNMAPPED;
            rvalid_reg <= 1'b0;
        end else begin
            global_cfg_reg <= global_cfg_next;
            tag_ctrl_reg <= tag_ctrl_next;
            steer_reg <= steer_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // Effective management mode, counter clear and steering outputs.
    always_comb begin
        mode_next = SMCR_MODE_NONE;
        if (!unmanaged_mode) begin
            unique case (global_cfg_reg[SMCR_SEL_HI:SMCR_SEL_LO])
                SMCR_SEL_NONE: begin
                    mode_next = SMCR_MODE_NONE;
                end
                SMCR_SEL_RSVD: begin
                    mode_next = SMCR_MODE_NONE;
                end
                SMCR_SEL_PRIMARY: begin
                    mode_next = SMCR_MODE_PRIMARY;
                end
                SMCR_SEL_DUAL: begin
                    mode_next = SMCR_MODE_DUAL;
                end
            endcase
        end
        clear_next = wr_global && global_cfg_reg[SMCR_CLEAR_BIT]
            && !reg_req.wdata[SMCR_CLEAR_BIT];
        tx_side_next = steer_reg[SMCR_STEER_WIDTH-1:0] & SMCR_STEER_USED_MASK;
        bpdu_next = '0;
        bpdu_next.valid = bpdu_valid;
        bpdu_next.port = SMCR_PORT_PRIMARY;
        bpdu_next.forward = bpdu_valid && global_cfg_reg[SMCR_BPDU_BIT]
            && (mode_reg != SMCR_MODE_NONE);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_reg <= SMCR_MODE_NONE;
            clear_reg <= 1'b0;
            tx_side_reg <= '0;
            bpdu_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            clear_reg <= clear_next;
            tx_side_reg <= tx_side_next;
            bpdu_reg <= bpdu_next;
        end
    end

    // Tag enables: secondary bit acts only while the secondary port is enabled.
    always_comb begin
        tag_eff[0] = tag_ctrl_reg[SMCR_TAG_PRI_BIT];
        tag_eff[1] = tag_ctrl_reg[SMCR_TAG_SEC_BIT] && (mode_reg == SMCR_MODE_DUAL);
    end

    smcr_cpu_route u_route (
        .clk_sys(clk_sys),
        .rst(rst),
        .mode(mode_reg),
        .req(cpu_req),
        .dest(cpu_dest)
    );

    smcr_tag_filter u_tag_primary (
        .clk_sys(clk_sys),
        .rst(rst),
        .tag_enable(tag_eff[0]),
        .rx_valid(mgmt_rx_valid[0]),
        .rx_has_tag(mgmt_rx_has_tag[0]),
        .tx_insert(tag_insert[0]),
        .rx_accept(mgmt_rx_accept[0]),
        .rx_discard(mgmt_rx_discard[0])
    );

    smcr_tag_filter u_tag_secondary (
        .clk_sys(clk_sys),
        .rst(rst),
        .tag_enable(tag_eff[1]),
        .rx_valid(mgmt_rx_valid[1]),
        .rx_has_tag(mgmt_rx_has_tag[1]),
        .tx_insert(tag_insert[1]),
        .rx_accept(mgmt_rx_accept[1]),
        .rx_discard(mgmt_rx_discard[1])
    );

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign counter_clear = clear_reg;
    assign counter_tx_side = tx_side_reg;
    assign bpdu_dest = bpdu_reg;
    assign active_mode = mode_reg;

endmodule : smcr_regs

`default_nettype wire

// file: sim/smcr_regs_assertions.sv
// Checker watching the ports of the management configuration register bank.
`default_nettype none
module smcr_regs_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire smcr_pkg::smcr_reg_req_type reg_req,
    input wire logic reg_rvalid,
    input wire logic unmanaged_mode,
    input wire smcr_pkg::smcr_cpu_req_type cpu_req,
    input wire smcr_pkg::smcr_dest_type cpu_dest,
    input wire logic bpdu_valid,
    input wire smcr_pkg::smcr_dest_type bpdu_dest,
    input wire logic counter_clear,
    input wire logic [1:0] mgmt_rx_valid,
    input wire logic [1:0] mgmt_rx_accept,
    input wire logic [1:0] mgmt_rx_discard,
    input wire logic [8:0] counter_tx_side,
    input wire logic [1:0] active_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import smcr_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_RD: assert property (reg_req.rd |=> reg_rvalid) else $error("read not answered");
    AST_PRI: assert property (cpu_req.valid && active_mode == 2'h1 |=>
        cpu_dest.forward && cpu_dest.port == 4'h8) else $error("primary route wrong");
    AST_DUAL: assert property (cpu_req.valid && cpu_req.from_wan && active_mode == 2'h2
        |=> cpu_dest.forward && cpu_dest.port == 4'h5) else $error("wan route wrong");
    AST_NONE: assert property (cpu_req.valid && active_mode == 2'h0
        |=> cpu_dest.valid && !cpu_dest.forward) else $error("route without port");
    AST_UNM: assert property (unmanaged_mode [*3] |-> active_mode == 2'h0)
        else $error("mode active while unmanaged");
    AST_BPDU: assert property (bpdu_valid |=> bpdu_dest.valid
        && (!bpdu_dest.forward || bpdu_dest.port == 4'h8)) else $error("bpdu trap wrong");
    AST_CLR: assert property (counter_clear |-> $past(reg_req.wr) && $past(reg_req.addr) == 8'h00
        && !$past(reg_req.wdata[0]) ##1 !counter_clear) else $error("clear pulse wrong");
    AST_RX: assert property (mgmt_rx_valid[0] |=> mgmt_rx_accept[0] != mgmt_rx_discard[0])
        else $error("ingress verdict wrong");
    AST_STR: assert property (counter_tx_side[7:6] == 2'h0)
        else $error("reserved steering bits set");
endmodule : smcr_regs_checker
bind smcr_regs smcr_regs_checker smcr_regs_checker_inst (.clk_sys, .rst, .reg_req, .reg_rvalid,
    .unmanaged_mode, .cpu_req, .cpu_dest, .bpdu_valid, .bpdu_dest, .counter_clear,
    .mgmt_rx_valid, .mgmt_rx_accept, .mgmt_rx_discard, .counter_tx_side, .active_mode);
`default_nettype wire

// file: sim/smcr_host_model.sv
// Host model sending frames into the management ports.
`default_nettype none
module smcr_host_model (
    input wire logic clk_sys,
    input wire logic [1:0] send,
    input wire logic flip,
    input wire logic [1:0] tag_enable,
    output logic [1:0] rx_valid,
    output logic [1:0] rx_has_tag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] junk = 2'h1;
    always @(posedge clk_sys) junk <= ~junk;
    assign rx_valid = send;
    assign rx_has_tag = (send & (tag_enable ^ {2{flip}})) | (~send & junk);
endmodule : smcr_host_model
`default_nettype wire

// file: sim/tb.sv
// Testbench for the management configuration register bank.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import smcr_pkg::*;
    logic clk_sys, rst, unm, bv, flip, rvalid, clr;
    smcr_reg_req_type rq;
    smcr_cpu_req_type cq;
    smcr_dest_type cd, bd;
    logic [7:0] rdata;
    logic [1:0] send, rxv, rxt, ti, acc, dis, am;
    logic [8:0] side;
    int n_mismatch, n_compared;
    smcr_regs smcr_regs_inst (.clk_sys(clk_sys), .rst(rst), .reg_req(rq), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .unmanaged_mode(unm), .cpu_req(cq), .cpu_dest(cd), .bpdu_valid(bv),
        .bpdu_dest(bd), .counter_clear(clr), .tag_insert(ti), .mgmt_rx_valid(rxv),
        .mgmt_rx_has_tag(rxt), .mgmt_rx_accept(acc), .mgmt_rx_discard(dis),
        .counter_tx_side(side), .active_mode(am));
    smcr_host_model smcr_host_model_inst (.clk_sys(clk_sys), .send(send), .flip(flip),
        .tag_enable(ti), .rx_valid(rxv), .rx_has_tag(rxt));
    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys) rq = '{1'b1, 1'b0, a, d};
        @(negedge clk_sys) rq.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys) rq = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_sys) rq.rd = 1'b0;
        chk({7'h00, rvalid, rdata}, {8'h01, e});
    endtask : rd
    task automatic ev(input logic w, input logic [3:0] p, input logic [3:0] bp);
        @(negedge clk_sys) begin
            cq = '{1'b1, w};
            bv = 1'b1;
        end
        @(negedge clk_sys) begin
            cq.valid = 1'b0;
            bv = 1'b0;
        end
        chk({4'h0, cd, bd}, {4'h0, 1'b1, p != 4'h0, p, 1'b1, bp != 4'h0, SMCR_PORT_PRIMARY});
    endtask : ev
    task automatic fr(input logic [1:0] s, input logic f, input logic [1:0] ea);
        @(negedge clk_sys) begin
            send = s;
            flip = f;
        end
        @(negedge clk_sys) send = 2'h0;
        chk({12'h000, acc, dis}, {12'h000, ea, s & ~ea});
    endtask : fr
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        logic [3:0] pl;
        rq = '0;
        cq = '0;
        {unm, bv, flip, send} = '0;
        rst = 1'b1;
        n_mismatch = 0;
        n_compared = 0;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h00);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h00);
        wr(8'h00, 8'h3C);
        rd(8'h00, 8'h3C);
        for (int m = 0; m < 4; m++) begin
            pl = (m >= 2) ? 4'h8 : 4'h0;
            wr(8'h00, {m[1:0], 6'h02});
            repeat (2) @(negedge clk_sys);
            chk({14'h0, am}, (m == 3) ? 16'h2 : (m == 2) ? 16'h1 : 16'h0);
            ev(1'b0, pl, pl);
            ev(1'b1, (m == 3) ? 4'h5 : pl, pl);
        end
        unm = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk({14'h0, am}, 16'h0);
        ev(1'b1, 4'h0, 4'h0);
        unm = 1'b0;
        wr(8'h00, 8'h80);
        repeat (2) @(negedge clk_sys);
        ev(1'b0, 4'h8, 4'h0);
        wr(8'h00, 8'h01);
        wr(8'h03, 8'h00);
        wr(8'h00, 8'h00);
        chk({15'h0, clr}, 16'h1);
        @(negedge clk_sys) chk({15'h0, clr}, 16'h0);
        wr(8'h00, 8'h00);
        chk({15'h0, clr}, 16'h0);
        wr(8'h00, 8'h80);
        wr(8'h03, 8'h03);
        repeat (3) @(negedge clk_sys);
        chk({14'h0, ti}, 16'h1);
        fr(2'h1, 1'b0, 2'h1);
        fr(2'h1, 1'b1, 2'h0);
        wr(8'h00, 8'hC0);
        repeat (3) @(negedge clk_sys);
        chk({14'h0, ti}, 16'h3);
        fr(2'h3, 1'b1, 2'h0);
        wr(8'h03, 8'h00);
        repeat (3) @(negedge clk_sys);
        chk({14'h0, ti}, 16'h0);
        fr(2'h3, 1'b1, 2'h3);
        fr(2'h3, 1'b0, 2'h3);
        wr(8'h04, 8'hFF);
        wr(8'h05, 8'h01);
        rd(8'h04, 8'hFF);
        rd(8'h05, 8'h01);
        chk({7'h00, side}, 16'h013F);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h05, 8'h00);
        chk({5'h00, side, am}, 16'h0000);
        stop_test();
    end
endmodule : tb
`default_nettype wire
